// ---- hw/pex_pkg.sv ----
// Constants, field layouts and helpers for the page exclusion access checker
package pex_pkg;
  // Capability block byte offsets
  localparam logic [3:0] OFF_HEADER = 4'h0;
  localparam logic [3:0] OFF_SELECT = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  // Capability header layout
  localparam logic [7:0] CAP_ID = 8'h0F;
  localparam logic [2:0] CAP_BLOCK_TYPE = 3'h0;
  localparam int HDR_NEXT_LSB = 8;
  localparam int HDR_TYPE_LSB = 16;
  localparam int HDR_MCE_BIT = 20;
  localparam int HDR_INTR_BIT = 21;
  // Indirect select layout
  localparam int SEL_INDEX_LSB = 0;
  localparam int SEL_FUNC_LSB = 8;
  // Function codes of the indirect select word
  localparam logic [2:0] FN_BASE_LO = 3'h0;
  localparam logic [2:0] FN_BASE_HI = 3'h1;
  localparam logic [2:0] FN_MAP = 3'h2;
  localparam logic [2:0] FN_CAP = 3'h3;
  localparam logic [2:0] FN_CTL = 3'h4;
  localparam logic [2:0] FN_ERR_STATUS = 3'h5;
  localparam logic [2:0] FN_ERR_ADDR_LO = 3'h6;
  localparam logic [2:0] FN_ERR_ADDR_HI = 3'h7;
  // Protection control register
  localparam int CTL_ENABLE = 0;
  localparam int CTL_IO_BLOCK = 2;
  localparam int CTL_FLUSH = 4;
  localparam int CTL_NO_SNOOP = 6;
  localparam logic [31:0] CTL_WMASK = 32'h0000005F;
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  // Table base low word layout; high word holds address bits 39:32
  localparam int BASE_V = 0;
  localparam int BASE_P = 1;
  localparam int BASE_SIZE_LSB = 2;
  localparam int BASE_ADDR_LSB = 12;
  localparam logic [31:0] BASE_HI_WMASK = 32'h000000FF;
  // Mapping register layout
  localparam int MAP_UNIT0_LSB = 0;
  localparam int MAP_V0 = 5;
  localparam int MAP_UNIT1_LSB = 6;
  localparam int MAP_V1 = 11;
  localparam int MAP_BUS_LSB = 12;
  localparam int MAP_DOM0_LSB = 20;
  localparam int MAP_DOM1_LSB = 26;
  // Sizes
  localparam int N_DOMAINS = 4;
  localparam int N_MAPS = 3;
  localparam int CAP_REV_LSB = 0;
  localparam int CAP_NMAPS_LSB = 8;
  localparam int CAP_NDOM_LSB = 16;
  // Address decomposition
  localparam int PAGE_SHIFT = 12;
  localparam int FRAME_W = 28;
  localparam int COVER_SHIFT = 20;
  localparam int WORD_IDX_W = 23;
  localparam int CACHE_IDX_W = 4;
  localparam int CACHE_DEPTH = 16;
  localparam int TAG_W = 21;
  // Error status layout
  localparam int ERR_VALID = 0;
  localparam int ERR_WRITE = 1;
  localparam int ERR_BUS_LSB = 8;
  localparam int ERR_UNIT_LSB = 16;
  // Request kinds
  localparam logic [1:0] KIND_MEM = 2'h0;
  localparam logic [1:0] KIND_IO = 2'h1;
  localparam logic [1:0] KIND_CFG = 2'h2;

  // Cache line slot of a page frame number
  function automatic logic [CACHE_IDX_W-1:0] cache_slot(input logic [FRAME_W-1:0] frame);
    cache_slot = frame[8:5];
  endfunction

  // Cache tag of a domain and page frame number
  function automatic logic [TAG_W-1:0] cache_tag(input logic [1:0] dom,
                                                 input logic [FRAME_W-1:0] frame);
    cache_tag = {dom, frame[27:9]};
  endfunction
endpackage

// ---- hw/domain_map_lookup.sv ----
// Requester bus/unit to protection domain lookup over the mapping registers
`timescale 1ns/1ps
module domain_map_lookup
  import pex_pkg::*;
(
  input wire logic [32*N_MAPS-1:0] maps,
  input wire logic [7:0] bus,
  input wire logic [4:0] unit,
  output logic [5:0] domain
);
  // First matching valid entry wins; no match leaves domain zero
  always_comb begin
    domain = 6'h00;
    for (int i = N_MAPS - 1; i >= 0; i--) begin
      if (maps[32*i+MAP_BUS_LSB +: 8] == bus) begin
        if (maps[32*i+MAP_V1] && maps[32*i+MAP_UNIT1_LSB +: 5] == unit) begin
          domain = maps[32*i+MAP_DOM1_LSB +: 6];
        end
        if (maps[32*i+MAP_V0] && maps[32*i+MAP_UNIT0_LSB +: 5] == unit) begin
          domain = maps[32*i+MAP_DOM0_LSB +: 6];
        end
      end
    end
  end
endmodule // domain_map_lookup

// ---- hw/bitmap_word_cache.sv ----
// Tag and data store for cached bitmap words, registered read port
`timescale 1ns/1ps
module bitmap_word_cache
  import pex_pkg::*;
(
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [CACHE_IDX_W-1:0] wr_idx,
  input wire logic [TAG_W+31:0] wr_data,
  input wire logic [CACHE_IDX_W-1:0] rd_idx,
  output logic [TAG_W+31:0] rd_data
);
  logic [TAG_W+31:0] mem [CACHE_DEPTH];

  // No reset on the array; line valid bits live with the checker
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule // bitmap_word_cache

// ---- hw/page_exclusion_access_checker.sv ----
// Host bridge page exclusion checker with its indirect capability registers
`timescale 1ns/1ps
module page_exclusion_access_checker
  import pex_pkg::*;
#(
  parameter logic [7:0] NEXT_CAP_PTR = 8'h00,
  parameter logic INTR_REPORT_CAP = 1'b0,
  parameter logic MCE_REPORT_CAP = 1'b0,
  parameter logic [7:0] CAP_REVISION = 8'h01 // Arbitrary revision value
)
(
  input wire logic mclk,
  input wire logic rst,
  // Processor configuration access to the capability block
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [3:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_done,
  // Upstream request from the bridge port, held until resp_valid
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_write,
  input wire logic req_from_cpu,
  input wire logic [7:0] req_bus,
  input wire logic [4:0] req_unit,
  input wire logic [39:0] req_addr,
  output logic resp_valid,
  output logic resp_abort,
  output logic resp_ones,
  // Bitmap word fetch from DRAM
  output logic fetch_valid,
  output logic [39:0] fetch_addr,
  output logic fetch_snoop,
  input wire logic fetch_ready,
  input wire logic fill_valid,
  input wire logic [31:0] fill_data
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_FETCH, ST_FILL} state_e;

  logic [31:0] select, ctl, err_status, err_addr_lo, err_addr_hi;
  logic [31:0] next_select, next_ctl, next_err_status, next_err_addr_lo, next_err_addr_hi;
  logic [31:0] base_lo [N_DOMAINS];
  logic [31:0] base_hi [N_DOMAINS];
  logic [31:0] next_base_lo [N_DOMAINS];
  logic [31:0] next_base_hi [N_DOMAINS];
  logic [32*N_MAPS-1:0] maps, next_maps;
  logic [31:0] next_cfg_rdata;
  logic next_cfg_done;

  state_e state, next_state;
  logic [1:0] r_dom, next_r_dom;
  logic [FRAME_W-1:0] r_frame, next_r_frame;
  logic r_write, next_r_write;
  logic [7:0] r_bus, next_r_bus;
  logic [4:0] r_unit, next_r_unit;
  logic [CACHE_DEPTH-1:0] line_valid, next_line_valid;
  logic next_resp_valid, next_resp_abort, next_resp_ones;
  logic next_fetch_valid, next_fetch_snoop;
  logic [39:0] next_fetch_addr;
  logic flush_clear, log_event;
  logic [5:0] map_dom;
  logic cache_wr;
  logic [TAG_W+31:0] cache_rd;
  logic [FRAME_W-1:0] req_frame;
  logic [2:0] sel_func;
  logic [7:0] sel_idx;

  assign req_frame = req_addr[39:PAGE_SHIFT];
  assign sel_func = select[SEL_FUNC_LSB +: 3];
  assign sel_idx = select[SEL_INDEX_LSB +: 8];

  // Local map table only; requests from other nodes never arrive on this port
  domain_map_lookup u_map (
    .maps(maps),
    .bus(req_bus),
    .unit(req_unit),
    .domain(map_dom)
  );

  // Fill data is written with the held tag; read slot follows the live request
  bitmap_word_cache u_cache (
    .mclk(mclk),
    .wr_en(cache_wr),
    .wr_idx(cache_slot(r_frame)),
    .wr_data({cache_tag(r_dom, r_frame), fill_data}),
    .rd_idx(cache_slot(req_frame)),
    .rd_data(cache_rd)
  );

  // True when the page lies beyond the span a table of this size covers
  function automatic logic beyond_span(input logic [FRAME_W-1:0] frame, input logic [4:0] size);
    logic [FRAME_W-1:0] hi;
    hi = frame >> (COVER_SHIFT + int'(size));
    beyond_span = |hi;
  endfunction

  // Read view of the internal register the select word names
  function automatic logic [31:0] internal_read(input logic [2:0] fn, input logic [7:0] idx);
    internal_read = 32'h00000000;
    case (fn)
      FN_BASE_LO: if (idx < 8'(N_DOMAINS)) internal_read = base_lo[idx[1:0]];
      FN_BASE_HI: if (idx < 8'(N_DOMAINS)) internal_read = base_hi[idx[1:0]];
      FN_MAP: if (idx < 8'(N_MAPS)) internal_read = maps[32*idx[1:0] +: 32];
      FN_CAP: begin
        internal_read[CAP_REV_LSB +: 8] = CAP_REVISION;
        internal_read[CAP_NMAPS_LSB +: 8] = 8'(N_MAPS);
        internal_read[CAP_NDOM_LSB +: 8] = 8'(N_DOMAINS);
      end
      FN_CTL: internal_read = ctl;
      FN_ERR_STATUS: internal_read = err_status;
      FN_ERR_ADDR_LO: internal_read = err_addr_lo;
      FN_ERR_ADDR_HI: internal_read = err_addr_hi;
      default: internal_read = 32'h00000000;
    endcase
  endfunction

  // Capability block decode, indirect writes, hardware updates to control and log
  always_comb begin
    logic [31:0] hdr;
    hdr = 32'h00000000;
    hdr[7:0] = CAP_ID;
    hdr[HDR_NEXT_LSB +: 8] = NEXT_CAP_PTR;
    hdr[HDR_TYPE_LSB +: 3] = CAP_BLOCK_TYPE;
    hdr[HDR_MCE_BIT] = MCE_REPORT_CAP;
    hdr[HDR_INTR_BIT] = INTR_REPORT_CAP;
    next_select = select;
    next_ctl = ctl;
    next_base_lo = base_lo;
    next_base_hi = base_hi;
    next_maps = maps;
    next_err_status = err_status;
    next_err_addr_lo = err_addr_lo;
    next_err_addr_hi = err_addr_hi;
    next_cfg_done = cfg_valid;
    next_cfg_rdata = 32'h00000000;
    // Hardware clears the flag once the cache is dropped
    if (flush_clear) begin
      next_ctl[CTL_FLUSH] = 1'b0;
    end
    if (cfg_valid && !cfg_write) begin
      case (cfg_addr)
        OFF_HEADER: next_cfg_rdata = hdr;
        OFF_SELECT: next_cfg_rdata = select;
        OFF_DATA: next_cfg_rdata = internal_read(sel_func, sel_idx);
        default: next_cfg_rdata = 32'h00000000;
      endcase
    end
    if (cfg_valid && cfg_write) begin
      case (cfg_addr)
        OFF_SELECT: next_select = cfg_wdata;
        OFF_DATA: begin
          case (sel_func)
            FN_BASE_LO: if (sel_idx < 8'(N_DOMAINS)) next_base_lo[sel_idx[1:0]] = cfg_wdata;
            FN_BASE_HI: if (sel_idx < 8'(N_DOMAINS)) begin
              next_base_hi[sel_idx[1:0]] = cfg_wdata & BASE_HI_WMASK;
            end
            FN_MAP: if (sel_idx < 8'(N_MAPS)) next_maps[32*sel_idx[1:0] +: 32] = cfg_wdata;
            // Software can set the flag but never cancel a pending flush
            FN_CTL: next_ctl = (cfg_wdata & CTL_WMASK) | (next_ctl & (32'h1 << CTL_FLUSH));
            // Writing one to the valid bit releases the log
            FN_ERR_STATUS: if (cfg_wdata[ERR_VALID]) next_err_status = 32'h00000000;
            default: next_ctl = next_ctl;
          endcase
        end
        default: next_select = select;
      endcase
    end
    // A new block event wins over a clear in the same cycle
    if (log_event && !next_err_status[ERR_VALID]) begin
      next_err_status = 32'h00000000;
      next_err_status[ERR_VALID] = 1'b1;
      next_err_status[ERR_WRITE] = r_write;
      next_err_status[ERR_BUS_LSB +: 8] = r_bus;
      next_err_status[ERR_UNIT_LSB +: 5] = r_unit;
      next_err_addr_lo = {r_frame[19:0], 12'h000};
      next_err_addr_hi = {24'h000000, r_frame[27:20]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      select <= 32'h00000000;
      ctl <= CTL_RESET;
      maps <= '0;
      err_status <= 32'h00000000;
      err_addr_lo <= 32'h00000000;
      err_addr_hi <= 32'h00000000;
      cfg_rdata <= 32'h00000000;
      cfg_done <= 1'b0;
      for (int i = 0; i < N_DOMAINS; i++) begin
        base_lo[i] <= 32'h00000000;
        base_hi[i] <= 32'h00000000;
      end
    end else begin
      select <= next_select;
      ctl <= next_ctl;
      maps <= next_maps;
      err_status <= next_err_status;
      err_addr_lo <= next_err_addr_lo;
      err_addr_hi <= next_err_addr_hi;
      cfg_rdata <= next_cfg_rdata;
      cfg_done <= next_cfg_done;
      base_lo <= next_base_lo;
      base_hi <= next_base_hi;
    end
  end

  // Request checking: decide on capture, else look up cache, else fetch the word
  always_comb begin
    logic [31:0] blo;
    logic hit_bit;
    blo = base_lo[map_dom[1:0]];
    hit_bit = 1'b0;
    next_state = state;
    next_r_dom = r_dom;
    next_r_frame = r_frame;
    next_r_write = r_write;
    next_r_bus = r_bus;
    next_r_unit = r_unit;
    next_line_valid = line_valid;
    next_resp_valid = 1'b0;
    next_resp_abort = 1'b0;
    next_resp_ones = 1'b0;
    next_fetch_valid = fetch_valid;
    next_fetch_addr = fetch_addr;
    next_fetch_snoop = fetch_snoop;
    flush_clear = 1'b0;
    log_event = 1'b0;
    cache_wr = 1'b0;
    case (state)
      ST_IDLE: begin
        if (ctl[CTL_FLUSH]) begin
          // Idle means no fetch is outstanding, so the drop is safe here
          next_line_valid = '0;
          flush_clear = 1'b1;
        end else if (req_valid && !resp_valid) begin
          next_r_frame = req_frame;
          next_r_dom = map_dom[1:0];
          next_r_write = req_write;
          next_r_bus = req_bus;
          next_r_unit = req_unit;
          next_resp_valid = 1'b1;
          if (req_from_cpu) begin
            next_resp_abort = 1'b0;
          end else if (req_kind == KIND_CFG) begin
            next_resp_abort = 1'b1;
          end else if (!ctl[CTL_ENABLE]) begin
            next_resp_abort = 1'b0;
          end else if (req_kind == KIND_IO) begin
            next_resp_abort = ctl[CTL_IO_BLOCK];
          end else if (map_dom >= 6'(N_DOMAINS) || !blo[BASE_V]) begin
            next_resp_abort = 1'b0;
          end else if (beyond_span(req_frame, blo[BASE_SIZE_LSB +: 5])) begin
            next_resp_abort = blo[BASE_P];
            next_resp_ones = blo[BASE_P] && !req_write;
            log_event = 1'b0;
          end else begin
            // Memory request inside the table: hold it for the bitmap bit
            next_resp_valid = 1'b0;
            next_state = ST_LOOKUP;
          end
          next_resp_ones = next_resp_abort && !req_write;
        end
      end
      ST_LOOKUP: begin
        hit_bit = cache_rd[r_frame[4:0]];
        if (line_valid[cache_slot(r_frame)] &&
            cache_rd[TAG_W+31:32] == cache_tag(r_dom, r_frame)) begin
          next_resp_valid = 1'b1;
          next_resp_abort = hit_bit;
          next_resp_ones = hit_bit && !r_write;
          log_event = hit_bit;
          next_state = ST_IDLE;
        end else begin
          // Word address: table base plus four bytes per 32 pages
          next_fetch_addr = {base_hi[r_dom][7:0], base_lo[r_dom][31:BASE_ADDR_LSB], 12'h000}
                            + {15'h0000, r_frame[27:5], 2'b00};
          next_fetch_snoop = !ctl[CTL_NO_SNOOP];
          next_fetch_valid = 1'b1;
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (fetch_ready) begin
          next_fetch_valid = 1'b0;
          next_state = ST_FILL;
        end
      end
      ST_FILL: begin
        if (fill_valid) begin
          hit_bit = fill_data[r_frame[4:0]];
          cache_wr = 1'b1;
          next_line_valid[cache_slot(r_frame)] = 1'b1;
          next_resp_valid = 1'b1;
          next_resp_abort = hit_bit;
          next_resp_ones = hit_bit && !r_write;
          log_event = hit_bit;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      r_dom <= 2'h0;
      r_frame <= '0;
      r_write <= 1'b0;
      r_bus <= 8'h00;
      r_unit <= 5'h00;
      line_valid <= '0;
      resp_valid <= 1'b0;
      resp_abort <= 1'b0;
      resp_ones <= 1'b0;
      fetch_valid <= 1'b0;
      fetch_addr <= 40'h0000000000;
      fetch_snoop <= 1'b0;
    end else begin
      state <= next_state;
      r_dom <= next_r_dom;
      r_frame <= next_r_frame;
      r_write <= next_r_write;
      r_bus <= next_r_bus;
      r_unit <= next_r_unit;
      line_valid <= next_line_valid;
      resp_valid <= next_resp_valid;
      resp_abort <= next_resp_abort;
      resp_ones <= next_resp_ones;
      fetch_valid <= next_fetch_valid;
      fetch_addr <= next_fetch_addr;
      fetch_snoop <= next_fetch_snoop;
    end
  end
endmodule // page_exclusion_access_checker

// ---- testbench/pex_checker.sv ----
// Port assertions for the page exclusion access checker
`timescale 1ns/1ps
module pex_checker
  import pex_pkg::*;
#(
  parameter logic [7:0] NEXT_CAP_PTR = 8'h00,
  parameter logic INTR_REPORT_CAP = 1'b0,
  parameter logic MCE_REPORT_CAP = 1'b0
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [3:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_done,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_write,
  input wire logic req_from_cpu,
  input wire logic resp_valid,
  input wire logic resp_abort,
  input wire logic resp_ones,
  input wire logic fetch_valid,
  input wire logic [39:0] fetch_addr,
  input wire logic fetch_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Config accesses answered exactly once, next cycle
  cfg_answer_a: assert property (cfg_valid |=> cfg_done)
    else $error("config access not answered");
  done_cause_a: assert property (cfg_done |-> $past(cfg_valid))
    else $error("config done without access");
  // Header is fixed apart from the build parameters
  header_value_a: assert property (cfg_valid && !cfg_write && cfg_addr == OFF_HEADER |=>
    cfg_rdata == {10'h000, INTR_REPORT_CAP, MCE_REPORT_CAP, 1'b0, CAP_BLOCK_TYPE,
    NEXT_CAP_PTR, CAP_ID})
    else $error("header value wrong");
  // Processor requests are never blocked
  cpu_pass_a: assert property (resp_valid && req_from_cpu |-> !resp_abort)
    else $error("processor request blocked");
  cfg_refuse_a: assert property (resp_valid && !req_from_cpu && req_kind == KIND_CFG |-> resp_abort)
    else $error("external config access passed");
  ones_read_a: assert property (resp_valid && req_kind == KIND_MEM |->
    resp_ones == (resp_abort && !req_write))
    else $error("all ones flag wrong");
  // Fetch held until accepted; request not answered meanwhile
  fetch_hold_a: assert property (fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_addr))
    else $error("fetch dropped before accept");
  no_early_a: assert property (fetch_valid |-> !resp_valid && req_valid && !req_from_cpu)
    else $error("answer during fetch");
  word_fetch_a: assert property (fetch_valid |-> fetch_addr[1:0] == 2'h0)
    else $error("fetch not word aligned");
  resp_pulse_a: assert property (resp_valid |=> !resp_valid)
    else $error("answer longer than a cycle");
endmodule // pex_checker

// ---- testbench/bitmap_dram_model.sv ----
// Bitmap memory answering word fetches, with adjustable latency
`timescale 1ns/1ps
module bitmap_dram_model (
  input wire logic mclk,
  input wire logic fetch_valid,
  input wire logic [39:0] fetch_addr,
  input wire logic fetch_snoop,
  input wire logic [3:0] delay,
  output logic fetch_ready,
  output logic fill_valid,
  output logic [31:0] fill_data
);
  logic [31:0] mem [0:15];
  logic [39:0] last_addr;
  logic last_snoop;
  // Accept after delay, fill later; released data shows the inverse
  initial begin
    fetch_ready = 1'b0;
    fill_valid = 1'b0;
    fill_data = 32'hA5A55A5A;
    forever begin
      @(posedge mclk);
      if (fetch_valid === 1'b1) begin
        repeat (delay) @(posedge mclk);
        fetch_ready <= 1'b1;
        @(posedge mclk);
        fetch_ready <= 1'b0;
        last_addr = fetch_addr;
        last_snoop = fetch_snoop;
        repeat (delay + 1) @(posedge mclk);
        fill_valid <= 1'b1;
        fill_data <= mem[last_addr[5:2]];
        @(posedge mclk);
        fill_valid <= 1'b0;
        fill_data <= ~mem[last_addr[5:2]];
      end
    end
  end
endmodule // bitmap_dram_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the page exclusion access checker
`timescale 1ns/1ps
module testbench;
  import pex_pkg::*;
  localparam logic [39:0] PG33 = 40'h0000021000;
  localparam logic [39:0] PG34 = 40'h0000022000;
  logic mclk, rst, cfg_valid, cfg_write, cfg_done, req_valid, req_write, req_from_cpu;
  logic resp_valid, resp_abort, resp_ones, fetch_valid, fetch_snoop, fetch_ready, fill_valid;
  logic [3:0] cfg_addr, delay;
  logic [31:0] cfg_wdata, cfg_rdata, rd, fill_data;
  logic [1:0] req_kind;
  logic [7:0] req_bus;
  logic [4:0] req_unit;
  logic [39:0] req_addr, fetch_addr;
  int fails = 0;
  int tests_run = 0;

  page_exclusion_access_checker u_dut (.mclk(mclk), .rst(rst), .cfg_valid(cfg_valid),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_done(cfg_done), .req_valid(req_valid), .req_kind(req_kind), .req_write(req_write),
    .req_from_cpu(req_from_cpu), .req_bus(req_bus), .req_unit(req_unit), .req_addr(req_addr),
    .resp_valid(resp_valid), .resp_abort(resp_abort), .resp_ones(resp_ones),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_snoop(fetch_snoop),
    .fetch_ready(fetch_ready), .fill_valid(fill_valid), .fill_data(fill_data));
  bitmap_dram_model u_mem (.mclk(mclk), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_snoop(fetch_snoop), .delay(delay), .fetch_ready(fetch_ready),
    .fill_valid(fill_valid), .fill_data(fill_data));

  // Free-running 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] sel(input logic [2:0] fn, input logic [7:0] idx);
    return {21'h000000, fn, idx};
  endfunction

  // One config access; done and data looked at in their only cycle
  task automatic cfg(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    cfg_valid <= 1'b1;
    cfg_write <= w;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_valid <= 1'b0;
    @(posedge mclk);
    check(cfg_done, 1'b1);
    rd = cfg_rdata;
  endtask

  task automatic wreg(input logic [31:0] s, input logic [31:0] d);
    cfg(1'b1, OFF_SELECT, s);
    cfg(1'b1, OFF_DATA, d);
  endtask

  task automatic rreg(input logic [31:0] s);
    cfg(1'b1, OFF_SELECT, s);
    cfg(1'b0, OFF_DATA, 32'h00000000);
  endtask

  // Request held until the answer; ones flag judged for memory only
  task automatic req(input logic [1:0] k, input logic w, input logic c, input logic [7:0] b,
                     input logic [39:0] a, input logic ea, input logic eo);
    int n;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_write <= w;
    req_from_cpu <= c;
    req_bus <= b;
    req_addr <= a;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (resp_valid !== 1'b1 && n < 200);
    check(resp_abort, ea);
    if (k == KIND_MEM) check(resp_ones, eo);
    req_valid <= 1'b0;
  endtask

  task automatic t_regs();
    cfg(1'b0, OFF_HEADER, 32'h00000000);
    check(rd, 32'h0000000F);
    cfg(1'b0, 4'hC, 32'h00000000);
    check(rd, 32'h00000000);
    rreg(sel(FN_CAP, 8'h00));
    check(rd, 32'h00040301);
    rreg(sel(FN_CTL, 8'h00));
    check(rd, 32'h00000000);
    // Unused domain 3, so the live tables are untouched
    wreg(sel(FN_BASE_HI, 8'h03), 32'hFFFFFFFF);
    rreg(sel(FN_BASE_HI, 8'h03));
    check(rd, 32'h000000FF);
  endtask

  // Domain 1 maps bus 2 unit 5, page 33 excluded; enable still off
  task automatic t_off();
    u_mem.mem[0] = 32'h00000000;
    u_mem.mem[1] = 32'h00000002;
    wreg(sel(FN_MAP, 8'h00), 32'h00102025);
    wreg(sel(FN_BASE_LO, 8'h01), 32'h00100001);
    rreg(sel(FN_BASE_LO, 8'h01));
    check(rd, 32'h00100001);
    req(KIND_MEM, 1'b0, 1'b0, 8'h02, PG33, 1'b0, 1'b0);
  endtask

  task automatic t_block();
    wreg(sel(FN_CTL, 8'h00), 32'h00000001);
    req(KIND_MEM, 1'b0, 1'b0, 8'h02, PG33, 1'b1, 1'b1);
    check(u_mem.last_addr, 40'h0000100004);
    check(u_mem.last_snoop, 1'b1);
    req(KIND_MEM, 1'b1, 1'b0, 8'h02, PG33, 1'b1, 1'b0);
    req(KIND_MEM, 1'b1, 1'b0, 8'h02, PG34, 1'b0, 1'b0);
    req(KIND_MEM, 1'b0, 1'b1, 8'h02, PG33, 1'b0, 1'b0);
    req(KIND_MEM, 1'b0, 1'b0, 8'h09, PG33, 1'b0, 1'b0);
    // First bitmap block is logged; later ones are not recorded while the log is held
    rreg(sel(FN_ERR_STATUS, 8'h00));
    check(rd, 32'h00050201);
    rreg(sel(FN_ERR_ADDR_LO, 8'h00));
    check(rd, 32'h00021000);
    wreg(sel(FN_ERR_STATUS, 8'h00), 32'h00000001);
    rreg(sel(FN_ERR_STATUS, 8'h00));
    check(rd, 32'h00000000);
  endtask

  task automatic t_kinds();
    req(KIND_CFG, 1'b0, 1'b0, 8'h02, PG33, 1'b1, 1'b0);
    req(KIND_CFG, 1'b0, 1'b1, 8'h02, PG33, 1'b0, 1'b0);
    req(KIND_IO, 1'b1, 1'b0, 8'h02, PG33, 1'b0, 1'b0);
    wreg(sel(FN_CTL, 8'h00), 32'h00000005);
    req(KIND_IO, 1'b1, 1'b0, 8'h02, PG33, 1'b1, 1'b0);
  endtask

  // Clear the page, invalidate with a slow far side, poll until done
  task automatic t_flush();
    int n;
    u_mem.mem[1] = 32'h00000000;
    delay = 4'h3;
    wreg(sel(FN_CTL, 8'h00), 32'h00000055);
    n = 0;
    do begin
      cfg(1'b0, OFF_DATA, 32'h00000000);
      n++;
    end while (rd[CTL_FLUSH] !== 1'b0 && n < 50);
    check(rd, 32'h00000045);
    req(KIND_MEM, 1'b0, 1'b0, 8'h02, PG33, 1'b0, 1'b0);
    check(u_mem.last_snoop, 1'b0);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset
  initial begin
    rst = 1'b1;
    delay = 4'h0;
    cfg_valid = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 4'h0;
    cfg_wdata = 32'h00000000;
    req_valid = 1'b0;
    req_kind = KIND_MEM;
    req_write = 1'b0;
    req_from_cpu = 1'b0;
    req_bus = 8'h00;
    req_unit = 5'h05;
    req_addr = 40'h0000000000;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_off();
    t_block();
    t_kinds();
    t_flush();
    complete_run();
  end

  // Hang guard, well past the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run();
  end
endmodule // testbench

bind page_exclusion_access_checker pex_checker #(.NEXT_CAP_PTR(NEXT_CAP_PTR),
  .INTR_REPORT_CAP(INTR_REPORT_CAP), .MCE_REPORT_CAP(MCE_REPORT_CAP)) u_chk (
  .mclk(mclk), .rst(rst), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
  .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_done(cfg_done), .req_valid(req_valid),
  .req_kind(req_kind), .req_write(req_write), .req_from_cpu(req_from_cpu),
  .resp_valid(resp_valid), .resp_abort(resp_abort), .resp_ones(resp_ones),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready));
